// File: core/stw_slave_port.sv
module stw_slave_port
  import stw_pkg::*;
#(
  // Register holding interrupt status; value arbitrary
  parameter logic [7:0] INT_STAT_ADDR = 8'h00,
  // Sample queue data register; value arbitrary
  parameter logic [7:0] QUEUE_ADDR = 8'h04
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic int_o,
  output logic int_oe,
  output logic [7:0] reg_addr,
  output logic [7:0] wr_data,
  output logic wr_stb,
  output logic rd_stb,
  input wire logic [7:0] rd_data,
  output logic selected
);

  // Whole state of the protocol engine
  typedef struct packed {
    stw_state_e st;      // Engine state
    logic [3:0] cnt;     // Clock rises seen in this byte
    logic rw;            // Direction bit of the address byte
    logic start_hi;      // Start seen in the current clock-high pulse
    logic scl_q;         // Previous synchronised clock
    logic sda_q;         // Previous synchronised data
    logic [7:0] ptr;     // Register pointer
    logic [7:0] addr;    // Address of the last strobe
    logic [7:0] wdat;    // Last written byte
    logic wr_stb;        // Write strobe
    logic rd_stb;        // Read strobe
    logic [7:0] tx;      // Byte being sent to the master
    logic drive_low;     // Pull data line low
    logic rdy_pend;      // Ready indication still pending
  } stw_core_s;

  stw_core_s core_reg;
  stw_core_s core_next;

  logic [1:0] line_s;    // Synchronised {clock, data}
  logic scl_s;           // Synchronised clock line
  logic sda_s;           // Synchronised data line
  logic [7:0] link_byte; // Bits captured in the link domain
  logic scl_rise;        // Clock went high
  logic scl_fall;        // Clock went low
  logic start_cond;      // Start or repeated start seen
  logic stop_cond;       // Stop seen

  // Next pointer: stays on the queue so repeated reads drain it
  function automatic logic [7:0] stw_advance(input logic [7:0] p);
    if (p == QUEUE_ADDR) begin
      stw_advance = p;
    end else begin
      stw_advance = p + 8'h01;
    end
  endfunction

  // Both lines sampled as inputs only; the clock is never driven.
  // Two flops cost two to three core cycles of latency, which is
  // tiny against a quarter of the fastest legal master bit time.
  stw_sync2 u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_i({scl_clk, sda_i}),
    .sync_o(line_s)
  );

  // Byte assembly runs on the master's own clock
  stw_link_shift u_link (
    .scl_clk(scl_clk),
    .rst_n(rst_n),
    .sda_i(sda_i),
    .byte_o(link_byte)
  );

  assign scl_s = line_s[1];
  assign sda_s = line_s[0];

  // Edges of the clock line, seen in the core domain
  assign scl_rise = scl_s & ~core_reg.scl_q;
  assign scl_fall = ~scl_s & core_reg.scl_q;

  // Data changing while the clock stays high is a control condition
  assign start_cond = scl_s & core_reg.scl_q &
    core_reg.sda_q & ~sda_s;
  assign stop_cond = scl_s & core_reg.scl_q &
    ~core_reg.sda_q & sda_s;

  // Protocol engine
  // Order of priority inside one core cycle:
  //   1. Start or repeated start, always re-enters the address phase
  //   2. Stop, unless a start came earlier in the same clock-high pulse
  //   3. Idle or skipped sessions, which ignore the clock entirely
  //   4. Clock rise, which counts a bit and takes what it carries
  //   5. Clock fall, which is the only time the data line may move
  // Bit counting:
  //   Count 0 to 7 are data bits, 8 is the acknowledge clock, and
  //   9 means the acknowledge clock has risen and waits for its fall.
  // Timing budget:
  //   The synchronised edges lag the wire by two to three core
  //   cycles. A master at the fastest legal rate keeps each clock
  //   phase for well over a hundred core cycles, so the data line is
  //   moved long before the next rise samples it.
  // Limitation:
  //   A master clock much faster than the core can resolve would
  //   merge edges; the supported rate leaves a wide margin here.
  // Cross-domain note:
  //   The link byte is read only after the synchronised rise, when
  //   it has stood still for several core cycles and will not move
  //   again until the next real rise one clock period later.
  always_comb begin
    core_next = core_reg;
    core_next.wr_stb = 1'b0;
    core_next.rd_stb = 1'b0;
    core_next.scl_q = scl_s;
    core_next.sda_q = sda_s;
    // High pulse ends, a later stop is honoured again
    if (scl_fall) begin
      core_next.start_hi = 1'b0;
    end
    if (start_cond) begin
      // Fresh or repeated start: re-address, keep the pointer
      core_next.st = STW_ADDR;
      core_next.cnt = STW_CNT_RST;
      core_next.drive_low = 1'b0;
      core_next.start_hi = 1'b1;
    end else if (stop_cond && !core_reg.start_hi) begin
      // Stop at any bit ends the session and frees the line
      core_next.st = STW_IDLE;
      core_next.cnt = STW_CNT_RST;
      core_next.drive_low = 1'b0;
    end else if (core_reg.st == STW_IDLE ||
                 core_reg.st == STW_SKIP) begin
      // Not addressed: clock ignored, line released
      core_next.drive_low = 1'b0;
    end else if (scl_rise) begin
      // One bit per clock rise
      core_next.cnt = core_reg.cnt + 4'h1;
      if (core_reg.cnt < STW_BYTE_BITS) begin
        case (core_reg.st)
          STW_ADDR: begin
            if (core_reg.cnt < STW_BYTE_TOP) begin
              // Identifier bit, MSB first; first mismatch drops out
              if (link_byte[0] !=
                  STW_SLAVE_ID[3'(STW_ID_TOP - core_reg.cnt)]) begin
                core_next.st = STW_SKIP;
              end
            end else begin
              // Last bit is the direction flag
              core_next.rw = link_byte[0];
            end
          end
          STW_REG: begin
            // Register address byte sets the pointer
            if (core_reg.cnt == STW_BYTE_TOP) begin
              core_next.ptr = link_byte;
            end
          end
          STW_WDATA: begin
            // Full data byte: strobe it out and advance
            if (core_reg.cnt == STW_BYTE_TOP) begin
              core_next.addr = core_reg.ptr;
              core_next.wdat = link_byte;
              core_next.wr_stb = 1'b1;
              core_next.ptr = stw_advance(core_reg.ptr);
            end
          end
          default: begin
            // Read bits come from this end, nothing to take
            core_next.st = core_reg.st;
          end
        endcase
      end else begin
        // Acknowledge clock rise
        if ((core_reg.st == STW_ADDR && core_reg.rw) ||
            (core_reg.st == STW_RDATA && !link_byte[0])) begin
          // Fetch the next byte a half clock before it is due
          core_next.addr = core_reg.ptr;
          core_next.rd_stb = 1'b1;
          core_next.ptr = stw_advance(core_reg.ptr);
          if (core_reg.ptr == INT_STAT_ADDR) begin
            core_next.rdy_pend = 1'b0;
          end
        end else if (core_reg.st == STW_RDATA) begin
          // Master refused the byte: read is over, wait for stop
          core_next.st = STW_SKIP;
        end
      end
    end else if (scl_fall) begin
      // Data line only changes while the clock is low
      case (core_reg.cnt)
        STW_BYTE_BITS: begin
          // Acknowledge slot: pull low if we were the receiver
          core_next.drive_low = (core_reg.st != STW_RDATA);
        end
        STW_ACK_DONE: begin
          // End of the nine-clock group
          core_next.cnt = STW_CNT_RST;
          core_next.drive_low = 1'b0;
          if (core_reg.st == STW_ADDR && !core_reg.rw) begin
            core_next.st = STW_REG;
          end else if (core_reg.st == STW_REG) begin
            core_next.st = STW_WDATA;
          end else if (core_reg.st == STW_ADDR ||
                       core_reg.st == STW_RDATA) begin
            // Present the MSB of the fetched byte
            core_next.st = STW_RDATA;
            core_next.tx = rd_data;
            core_next.drive_low = ~rd_data[7];
          end
        end
        default: begin
          // Remaining read bits, MSB first
          if (core_reg.st == STW_RDATA) begin
            core_next.drive_low =
              ~core_reg.tx[3'(STW_BYTE_TOP - core_reg.cnt)];
          end
        end
      endcase
    end
  end

  // Register the whole engine; ready indication pending at power-up.
  // Edge history resets to the idle-high bus level, so no false edge
  // or false start is seen in the first cycles after reset.
  // The pointer resets to zero; a write of the register byte sets it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_reg <= '{
        st: STW_IDLE,
        cnt: STW_CNT_RST,
        rw: 1'b0,
        start_hi: 1'b0,
        scl_q: 1'b1,
        sda_q: 1'b1,
        ptr: STW_BYTE_RST,
        addr: STW_BYTE_RST,
        wdat: STW_BYTE_RST,
        wr_stb: 1'b0,
        rd_stb: 1'b0,
        tx: STW_BYTE_RST,
        drive_low: 1'b0,
        rdy_pend: 1'b1
      };
    end else begin
      core_reg <= core_next;
    end
  end

  // Open-drain data line: only ever pulls low.
  // The enable comes straight from a flop, so it never glitches
  // while the master's clock is high.
  assign sda_o = 1'b0;
  assign sda_oe = core_reg.drive_low;

  // Open-drain interrupt, low while ready is pending.
  // Only the readiness event lives here; other interrupt sources
  // belong to the register file behind this port.
  assign int_o = 1'b0;
  assign int_oe = core_reg.rdy_pend;

  // Register-side outputs from flip-flops; selected is decoded from the state.
  // Strobes last one core cycle and are at least one master clock
  // period apart, so the register file needs no queue.
  assign reg_addr = core_reg.addr;
  assign wr_data = core_reg.wdat;
  assign wr_stb = core_reg.wr_stb;
  assign rd_stb = core_reg.rd_stb;
  assign selected = (core_reg.st != STW_IDLE) &&
    (core_reg.st != STW_SKIP);

endmodule

// File: core/stw_pkg.sv
// Shared constants of the two-wire slave port
package stw_pkg;

  // Fixed seven-bit slave identifier, sent MSB first
  localparam logic [6:0] STW_SLAVE_ID = 7'h57;

  // Data bits in one byte on the wire
  localparam logic [3:0] STW_BYTE_BITS = 4'h8;

  // Bit count after the acknowledge clock has risen
  localparam logic [3:0] STW_ACK_DONE = 4'h9;

  // Top bit index of the identifier and of a byte
  localparam logic [3:0] STW_ID_TOP = 4'h6;
  localparam logic [3:0] STW_BYTE_TOP = 4'h7;

  // Reset values
  localparam logic [3:0] STW_CNT_RST = 4'h0;
  localparam logic [7:0] STW_BYTE_RST = 8'h00;

  // Highest master clock rate supported, in kHz
  localparam int STW_SCL_MAX_KHZ = 400;

  // Core clock rate, in MHz
  localparam int STW_CLK_MHZ = 200;

  // Shortest master clock period in core cycles, rounded down
  localparam int STW_SCL_MIN_CYC = STW_CLK_MHZ * 1000 / STW_SCL_MAX_KHZ;

  // Protocol engine states
  typedef enum logic [2:0] {
    STW_IDLE = 3'h0,
    STW_ADDR = 3'h1,
    STW_REG = 3'h2,
    STW_WDATA = 3'h3,
    STW_RDATA = 3'h4,
    STW_SKIP = 3'h5
  } stw_state_e;

endpackage

// File: core/stw_sync2.sv
// Two-stage synchroniser for the bus lines into the core clock
module stw_sync2
  import stw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] async_i,
  output logic [1:0] sync_o
);

  // First stage feeds only the second stage
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
  } stw_sync_s;

  stw_sync_s sync_reg;
  stw_sync_s sync_next;

  // Shift both stages; idle bus level is high
  always_comb begin
    sync_next = sync_reg;
    sync_next.meta = async_i;
    sync_next.sync = sync_reg.meta;
  end

  // Reset to the idle-high bus level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_reg <= '1;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg.sync;

endmodule

// File: core/stw_link_shift.sv
// Bit shifter clocked by the master's serial clock
module stw_link_shift
  import stw_pkg::*;
(
  input wire logic scl_clk,
  input wire logic rst_n,
  input wire logic sda_i,
  output logic [7:0] byte_o
);

  // Only state of the link domain
  typedef struct packed {
    logic [7:0] shift;
  } stw_link_s;

  stw_link_s link_reg;
  stw_link_s link_next;

  // Newest bit enters at the bottom, MSB leaves first
  always_comb begin
    link_next = link_reg;
    link_next.shift = {link_reg.shift[6:0], sda_i};
  end

  // Data line is stable while the clock is high, so sample on the rise
  always_ff @(posedge scl_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  // Held steady for a whole clock period; the core reads it after the
  // synchronised rise, long before the next real rise can move it
  assign byte_o = link_reg.shift;

endmodule

// File: bench/stw_master_model.sv
// Bus master stand-in: owns the serial clock, drives data open-drain
module stw_master_model #(
  // Quarter bit time in core cycles, 2.5 us bit
  parameter int Q = 125
) (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl_clk,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus: clock stands high, data released
  initial begin
    scl_clk = 1'b1;
    sda_pull = 1'b0;
  end

  // Quarter wait; every change lands on a falling core edge
  task automatic qw();
    repeat (Q) @(negedge clk);
  endtask

  // One bit: data set mid-low, sampled mid-high, held all high time
  task automatic xbit(input logic b, output logic r);
    sda_pull = !b;
    qw();
    scl_clk = 1'b1;
    qw();
    r = sda_line;
    qw();
    scl_clk = 1'b0;
    qw();
  endtask

  // Start or repeated start from either clock level
  task automatic start();
    sda_pull = 1'b0;
    qw();
    scl_clk = 1'b1;
    qw();
    sda_pull = 1'b1;
    qw();
    scl_clk = 1'b0;
    qw();
  endtask

  // Stop, never after a start in the same high pulse
  task automatic stop();
    sda_pull = 1'b1;
    qw();
    scl_clk = 1'b1;
    qw();
    sda_pull = 1'b0;
    qw();
  endtask

  // Eight bits MSB first, then the acknowledge clock
  task automatic xbyte(input logic [7:0] d, input logic a,
                       output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--)
      xbit(d[i], q[i]);
    xbit(a, k);
  endtask
endmodule

// File: bench/stw_slave_port_monitor.sv
// Port checker; sees only the pins of the slave port
module stw_slave_port_monitor #(
  parameter logic [7:0] INT_STAT_ADDR = 8'h00
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_clk,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic int_o,
  input wire logic int_oe,
  input wire logic [7:0] reg_addr,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic selected
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_sda_pull_only: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  chk_int_pull_only: assert property (int_o == 1'b0)
    else $error("interrupt pin driven high");
  // Data may only move well inside the clock low phase
  chk_oe_scl_low: assert property ($changed(sda_oe) |->
    !scl_clk && !$past(scl_clk, 2)) else $error("data moved near clock high");
  chk_strobe_gap: assert property ((wr_stb || rd_stb) |=>
    (!wr_stb && !rd_stb) [*8]) else $error("strobes too close");
  chk_strobe_sel: assert property ((wr_stb || rd_stb) |-> selected)
    else $error("strobe while not addressed");
  chk_unsel_quiet: assert property (!selected |-> !sda_oe)
    else $error("data pulled while not addressed");
  chk_start_sel: assert property (
    scl_clk && $past(scl_clk) && $fell(sda_i) |-> ##[1:8] selected)
    else $error("start not taken");
  chk_stop_free: assert property (
    scl_clk && $past(scl_clk) && $rose(sda_i) |-> ##[1:8] !selected)
    else $error("stop not taken");
  // Ready flag only drops, and only on a status fetch
  chk_int_clear: assert property ($changed(int_oe) |-> !int_oe &&
    reg_addr == INT_STAT_ADDR && (rd_stb || $past(rd_stb)))
    else $error("ready flag changed wrongly");

  cover property (wr_stb);
  cover property (rd_stb);
  cover property ($fell(int_oe));
endmodule

bind stw_slave_port stw_slave_port_monitor #(
  .INT_STAT_ADDR(INT_STAT_ADDR)
) u_mon (
  .clk(clk), .rst_n(rst_n), .scl_clk(scl_clk), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .int_o(int_o), .int_oe(int_oe),
  .reg_addr(reg_addr), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .selected(selected)
);

// File: bench/testbench.sv
// Self-checking bench for the two-wire slave port
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import stw_pkg::*;

  localparam logic [7:0] ISTAT = 8'h00; // Status register, arbitrary
  localparam logic [7:0] QADDR = 8'h04; // Sample queue, arbitrary
  localparam logic [7:0] WID = {STW_SLAVE_ID, 1'b0}; // Write address
  logic clk, rst_n, scl_clk, sda_pull, sda_i, sda_o, sda_oe, k;
  logic int_o, int_oe, wr_stb, rd_stb, selected;
  logic [7:0] reg_addr, wr_data, rd_data, salt, q;
  logic [15:0] wq[$]; // Captured writes: address, data
  int mismatches = 0;
  int samples_checked = 0;

  // Wired-AND data line with pull-up
  assign sda_i = !sda_pull && (sda_oe ? sda_o : 1'b1);

  stw_slave_port #(.INT_STAT_ADDR(ISTAT), .QUEUE_ADDR(QADDR)) dut (
    .clk(clk), .rst_n(rst_n), .scl_clk(scl_clk), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .int_o(int_o), .int_oe(int_oe),
    .reg_addr(reg_addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .selected(selected));

  stw_master_model m (.clk(clk), .sda_line(sda_i), .scl_clk(scl_clk),
    .sda_pull(sda_pull));

  // Core clock, 5 ns
  initial begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end

  // Register file stand-in; byte held until the next fetch
  always @(negedge clk) begin
    if (wr_stb === 1'b1)
      wq.push_back({reg_addr, wr_data});
    if (rd_stb === 1'b1)
      rd_data <= reg_addr ^ salt;
  end

  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    return a ^ salt;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Master writes a byte and looks at the acknowledge
  task automatic snd(input logic [7:0] d, input logic ek);
    m.xbyte(d, 1'b1, q, k);
    chk(16'(k), 16'(ek));
  endtask

  // Master reads a byte, then acks (0) or nacks (1)
  task automatic rcv(input logic a, input logic [7:0] addr);
    m.xbyte(8'hff, a, q, k);
    chk(16'(q), 16'(exp_rd(addr)));
  endtask

  // Exactly two write strobes, as expected
  task automatic wcheck(input logic [15:0] w0, input logic [15:0] w1);
    chk(16'(wq.size()), 16'h0002);
    chk(wq[0], w0);
    chk(wq[1], w1);
    wq.delete();
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  initial begin
    logic [7:0] r, d0, d1;
    logic [6:0] bad;
    rst_n = 1'b0;
    rd_data = 8'h00;
    void'($urandom(32'hbc5a445f));
    salt = 8'($urandom);
    r = 8'($urandom);
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    bad = STW_SLAVE_ID ^ (7'h01 << ($urandom % 7)); // One wrong bit
    if (r == QADDR)
      r = 8'h10;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    chk(16'({int_oe, sda_oe, selected}), 16'h0004);
    repeat (3) @(negedge clk);
    // Write two bytes at a random address
    m.start();
    snd(WID, 1'b0);
    snd(r, 1'b0);
    snd(d0, 1'b0);
    snd(d1, 1'b0);
    m.stop();
    wcheck({r, d0}, {r + 8'h01, d1});
    chk(16'({selected, int_oe}), 16'h0001);
    // Stop in mid-byte
    m.start();
    snd(WID, 1'b0);
    repeat (3) m.xbit(1'b0, k);
    m.stop();
    chk(16'({selected, 8'(wq.size())}), 16'h0000);
    // Wrong identifier: no ack, no strobe until next start
    m.start();
    snd({bad, 1'b0}, 1'b1);
    snd(r, 1'b1);
    m.stop();
    chk(16'(wq.size()), 16'h0000);
    // Sample queue keeps the pointer
    m.start();
    snd(WID, 1'b0);
    snd(QADDR, 1'b0);
    snd(d1, 1'b0);
    snd(d0, 1'b0);
    m.stop();
    wcheck({QADDR, d1}, {QADDR, d0});
    // Status read through a repeated start clears the ready flag
    m.start();
    snd(WID, 1'b0);
    snd(ISTAT, 1'b0);
    m.start();
    snd({STW_SLAVE_ID, 1'b1}, 1'b0);
    rcv(1'b0, ISTAT);
    rcv(1'b1, ISTAT + 8'h01);
    m.stop();
    chk(16'({selected, int_oe}), 16'h0000);
    wrap_up();
  end
endmodule
